/* File: hdl/ram_motor_command.sv */
// Two-channel analog / servo-pulse motor command decoder with fault handling
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Analog duty is (reading minus 128) times 8, 256 steps.
// - Servo width 1.44 to 1.56 ms gives zero duty.
// - Servo width 0.5 to 1.08 ms gives full reverse.
// - Servo width 1.91 to 2.5 ms gives full forward.
// - 1.08 to 1.44 ms gives reverse proportional to distance below band.
// - 1.56 to 1.91 ms gives forward proportional to distance above band.
// - Invalid width gives zero duty without clearing a fault; a stuck line loads a neutral 1.5 ms pulse.
// - One fault flag per motor, set by over-current or over-temperature.
// - Analog over-current resets that drive's duty to zero.
// - Analog fault stays until the reading returns into the dead band.
// - Servo fault clears once width returns into 1.44 to 1.56 ms.
// - Analog below mid-scale runs reverse, above runs forward.
// - Analog and servo modes free-spin unless the strap is grounded.
module ram_motor_command #(
  parameter logic [14:0] TIMEOUT_TICKS = 15'(ram_pkg::RC_TIMEOUT_TICKS)
) (
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  input  wire logic [1:0]               mode_pins,
  input  wire logic                     addr_strap_b,
  input  wire logic                     channel_one_command_input,
  input  wire logic                     channel_two_command_input,
  input  wire ram_pkg::ram_bridge_t [1:0] bridge_status,
  input  wire ram_pkg::ram_adc_t [1:0]  adc_sample,
  input  wire ram_pkg::ram_duty_t [1:0] serial_duty,
  input  wire logic [1:0]               clear_fault_cmd,
  input  wire logic                     serial_brake_free,
  output logic [2:0]                    mode_state,
  output ram_pkg::ram_drive_t [1:0]     drive,
  output logic                          first_drive_fault_flag,
  output logic                          second_drive_fault_flag,
  output logic                          dynamic_brake
);

  // Servo magnitude from width; divide replaced by gain and shift
  function automatic ram_pkg::ram_duty_t rc_duty(input logic [14:0] w);
    logic [14:0] d;
    logic [22:0] p;
    d = 15'h0000;
    p = 23'h000000;
    rc_duty = 12'sh000;
    if (w >= ram_pkg::W_MIN && w <= ram_pkg::REV_FULL)
    begin
      rc_duty = -ram_pkg::DUTY_FULL;
    end
    else if (w > ram_pkg::REV_FULL && w < ram_pkg::DB_LO)
    begin
      d = ram_pkg::DB_LO - w;
      p = 23'(d) * 23'(ram_pkg::REV_GAIN);
      rc_duty = -$signed({1'b0, p[ram_pkg::REV_SHIFT +: 11]});
    end
    else if (w > ram_pkg::DB_HI && w < ram_pkg::FWD_FULL)
    begin
      d = w - ram_pkg::DB_HI;
      p = 23'(d) * 23'(ram_pkg::FWD_GAIN);
      rc_duty = $signed({1'b0, p[ram_pkg::FWD_SHIFT +: 11]});
    end
    else if (w >= ram_pkg::FWD_FULL && w <= ram_pkg::W_MAX)
    begin
      rc_duty = ram_pkg::DUTY_FULL;
    end
    else
    begin
      rc_duty = 12'sh000;
    end
  endfunction

  // Pin synchronisers: three stages, a change counts once stages two and three agree
  logic [ram_pkg::PIN_W-1:0] pins_raw;
  logic [ram_pkg::PIN_W-1:0] sy1_reg;
  logic [ram_pkg::PIN_W-1:0] sy2_reg;
  logic [ram_pkg::PIN_W-1:0] sy3_reg;
  logic [ram_pkg::PIN_W-1:0] flt_reg;
  logic [ram_pkg::PIN_W-1:0] flt_next;

  assign pins_raw = {mode_pins, addr_strap_b,
                     bridge_status[1].over_temp, bridge_status[0].over_temp,
                     bridge_status[1].over_current, bridge_status[0].over_current,
                     channel_two_command_input, channel_one_command_input};

  // Hold the filtered level while stages two and three disagree
  always_comb
  begin
    flt_next = (flt_reg & (sy2_reg ^ sy3_reg)) | (sy3_reg & ~(sy2_reg ^ sy3_reg));
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sy1_reg <= ram_pkg::PIN_RST;
      sy2_reg <= ram_pkg::PIN_RST;
      sy3_reg <= ram_pkg::PIN_RST;
      flt_reg <= ram_pkg::PIN_RST;
    end
    else
    begin
      sy1_reg <= pins_raw;
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
      flt_reg <= flt_next;
    end
  end

  // Mode, brake style and microsecond tick
  ram_pkg::ram_mode_t mode_reg;
  ram_pkg::ram_mode_t mode_next;
  logic               brake_reg;
  logic               brake_next;
  logic [7:0]         pre_reg;
  logic [7:0]         pre_next;
  logic               tick_reg;
  logic               tick_next;

  always_comb
  begin
    case (flt_reg[ram_pkg::P_MODE +: 2])
      ram_pkg::MODE_PIN_ANALOG: mode_next = ram_pkg::MODE_ANALOG;
      ram_pkg::MODE_PIN_RC:     mode_next = ram_pkg::MODE_RC;
      default:                  mode_next = ram_pkg::MODE_SERIAL;
    endcase
    // Serial mode takes brake style from the host; the strap applies elsewhere
    case (mode_reg)
      ram_pkg::MODE_SERIAL: brake_next = ~serial_brake_free;
      default:              brake_next = ~flt_reg[ram_pkg::P_STRAP];
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_reg  <= ram_pkg::MODE_ANALOG;
      brake_reg <= 1'b0;
    end
    else
    begin
      mode_reg  <= mode_next;
      brake_reg <= brake_next;
    end
  end

  // Free-running tick; its phase against a pulse edge costs up to 1 us of width
  always_comb
  begin
    tick_next = (pre_reg == ram_pkg::TICK_LAST);
    pre_next  = tick_next ? 8'h00 : pre_reg + 8'h01;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pre_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end
    else
    begin
      pre_reg  <= pre_next;
      tick_reg <= tick_next;
    end
  end

  // Bridge fault pins after synchronisation; over-temperature counts like over-current
  function automatic logic bridge_status_set(input int ch);
    bridge_status_set = flt_reg[ram_pkg::P_OC + ch] | flt_reg[ram_pkg::P_OT + ch];
  endfunction

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_ch
      logic        lvl;
      logic        prev_reg;
      logic [14:0] cnt_reg;
      logic [14:0] cnt_next;
      logic [14:0] width_reg;
      logic [14:0] width_next;
      logic [7:0]  samp_reg;
      logic [7:0]  samp_next;
      logic        fault_next;
      logic        fault_reg;
      logic        clr;
      ram_pkg::ram_drive_t drv_reg;
      ram_pkg::ram_duty_t  cmd;
      ram_pkg::ram_drive_t drv_next;

      // Command levels come from the filtered pin vector, never from the raw pins
      assign lvl = flt_reg[ram_pkg::P_CMD + i];

      // Width counter in 1 us ticks, restarted on every edge, saturating
      always_comb
      begin
        cnt_next   = cnt_reg;
        width_next = width_reg;
        if (lvl != prev_reg)
        begin
          cnt_next = 15'h0000;
        end
        // A saturated count reads as an invalid width instead of wrapping into range
        else if (tick_reg && cnt_reg != 15'h7fff)
        begin
          cnt_next = cnt_reg + 15'h0001;
        end
        if (prev_reg && !lvl)
        begin
          width_next = cnt_reg;
        end
        else if (prev_reg && lvl && cnt_reg > ram_pkg::W_MAX)
        begin
          width_next = ram_pkg::NEUTRAL;
        end
        else if (!prev_reg && !lvl && cnt_reg >= TIMEOUT_TICKS)
        begin
          width_next = ram_pkg::NEUTRAL;
        end
        samp_next = adc_sample[i].valid ? adc_sample[i].data : samp_reg;
      end

      // Fault clear source and command duty per mode; a set beats a clear
      always_comb
      begin
        case (mode_reg)
          ram_pkg::MODE_ANALOG:
          begin
            clr = samp_reg >= ram_pkg::ADC_DB_LO && samp_reg <= ram_pkg::ADC_DB_HI;
            cmd = {~samp_reg[7], ~samp_reg[7], samp_reg[6:0], 3'b000};
          end
          ram_pkg::MODE_RC:
          begin
            clr = width_reg >= ram_pkg::DB_LO && width_reg <= ram_pkg::DB_HI;
            cmd = rc_duty(width_reg);
          end
          ram_pkg::MODE_SERIAL:
          begin
            clr = clear_fault_cmd[i];
            cmd = serial_duty[i];
          end
          default:
          begin
            clr = 1'b0;
            cmd = 12'sh000;
          end
        endcase
        // Serial clear is a one-cycle command; analog and servo clears are levels
        fault_next = bridge_status_set(i) | (fault_reg & ~clr);
        drv_next.enable = ~fault_next;
        drv_next.duty   = fault_next ? 12'sh000 : cmd;
      end

      // Width is latched at a fall or loaded with NEUTRAL on a stuck line; a rising edge leaves the last command in force
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          prev_reg  <= 1'b0;
          cnt_reg   <= 15'h0000;
          width_reg <= ram_pkg::NEUTRAL;
          samp_reg  <= ram_pkg::ADC_MID;
        end
        else
        begin
          prev_reg  <= lvl;
          cnt_reg   <= cnt_next;
          width_reg <= width_next;
          samp_reg  <= samp_next;
        end
      end

      // Flag and drive share one edge, so a faulted bridge is never seen enabled
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          fault_reg <= 1'b0;
          drv_reg   <= '0;
        end
        else
        begin
          fault_reg <= fault_next;
          drv_reg   <= drv_next;
        end
      end
    end
  endgenerate

  // Outputs straight from registers; each channel keeps its own flag and drive
  assign drive                   = {g_ch[1].drv_reg, g_ch[0].drv_reg};
  assign first_drive_fault_flag  = g_ch[0].fault_reg;
  assign second_drive_fault_flag = g_ch[1].fault_reg;
  assign dynamic_brake           = brake_reg;
  assign mode_state              = mode_reg;

endmodule
`default_nettype wire

/* File: common/ram_pkg.sv */
// Shared constants and carrier types for the motor command block
`default_nettype none
package ram_pkg;
  // Clock and measurement tick
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
  // Servo pulse limits, in microsecond ticks
  localparam int CW = 15;
  localparam logic [CW-1:0] W_MIN    = 15'h01f4; // 0.5 ms
  localparam logic [CW-1:0] REV_FULL = 15'h0438; // 1.08 ms
  localparam logic [CW-1:0] DB_LO    = 15'h05a0; // 1.44 ms
  localparam logic [CW-1:0] NEUTRAL  = 15'h05dc; // 1.5 ms
  localparam logic [CW-1:0] DB_HI    = 15'h0618; // 1.56 ms
  localparam logic [CW-1:0] FWD_FULL = 15'h0776; // 1.91 ms
  localparam logic [CW-1:0] W_MAX    = 15'h09c4; // 2.5 ms
  localparam int RC_PERIOD_MS = 25;
  localparam int RC_TIMEOUT_TICKS = RC_PERIOD_MS * 1000;
  // Proportional gains: 360 us and 350 us spans onto 1023
  localparam logic [7:0] REV_GAIN  = 8'h5b;
  localparam int         REV_SHIFT = 5;
  localparam logic [7:0] FWD_GAIN  = 8'hbb;
  localparam int         FWD_SHIFT = 6;
  localparam logic signed [11:0] DUTY_FULL = 12'sh3ff;
  // Analog dead band on the 8-bit reading, and reading at reset
  localparam logic [7:0] ADC_DB_LO = 8'h7c;
  localparam logic [7:0] ADC_DB_HI = 8'h84;
  localparam logic [7:0] ADC_MID   = 8'h80;
  // Synchronised pin vector layout
  localparam int P_CMD   = 0;
  localparam int P_OC    = 2;
  localparam int P_OT    = 4;
  localparam int P_STRAP = 6;
  localparam int P_MODE  = 7;
  localparam int PIN_W   = 9;
  localparam logic [PIN_W-1:0] PIN_RST = 9'h040;
  localparam logic [1:0] MODE_PIN_ANALOG = 2'h0;
  localparam logic [1:0] MODE_PIN_RC     = 2'h1;

  typedef enum logic [2:0] {
    MODE_ANALOG = 3'h1,
    MODE_RC     = 3'h2,
    MODE_SERIAL = 3'h4
  } ram_mode_t;

  typedef logic signed [11:0] ram_duty_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ram_adc_t;

  typedef struct packed {
    logic over_current;
    logic over_temp;
  } ram_bridge_t;

  typedef struct packed {
    logic      enable;
    ram_duty_t duty;
  } ram_drive_t;
endpackage
`default_nettype wire

/* File: sim/ram_cmd_chk_sva.sv */
// Checker bound to the motor command block
`timescale 1ns/100ps
`default_nettype none
module ram_cmd_chk (
  input wire logic                       clock,
  input wire logic                       rst_b,
  input wire logic                       addr_strap_b,
  input wire ram_pkg::ram_bridge_t [1:0] bridge_status,
  input wire ram_pkg::ram_adc_t [1:0]    adc_sample,
  input wire logic [2:0]                 mode_state,
  input wire ram_pkg::ram_drive_t [1:0]  drive,
  input wire logic                       first_drive_fault_flag,
  input wire logic                       second_drive_fault_flag,
  input wire logic                       dynamic_brake
);
  logic [7:0]        rd_reg;
  logic [7:0]        rd_next;
  logic              band;
  logic              ana;
  logic signed [11:0] want;
  // Mirror of the stored channel one reading
  always_comb rd_next = adc_sample[0].valid ? adc_sample[0].data : rd_reg;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      rd_reg <= 8'h80;
    else
      rd_reg <= rd_next;
  assign band = rd_reg >= 8'h7c && rd_reg <= 8'h84;
  assign ana  = mode_state == 3'h1;
  // Reading minus mid-scale, times eight, without a multiplier
  assign want = {~rd_reg[7], ~rd_reg[7], rd_reg[6:0], 3'h0};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_drive_one_off: assert property (
    first_drive_fault_flag [*2] |-> drive[0] == 13'h0000) else $error("drive one live in fault");
  a_drive_two_off: assert property (
    $past(second_drive_fault_flag) && second_drive_fault_flag |-> !drive[1].enable)
    else $error("drive two live in fault");
  a_analog_duty_map: assert property (
    ana && adc_sample[0].valid ##1 !adc_sample[0].valid |-> ##1
    (first_drive_fault_flag || $past(first_drive_fault_flag) || drive[0].duty == want))
    else $error("analog duty wrong");
  a_fault_sets_flag: assert property (
    (bridge_status[0] != 2'h0) [*3] |-> ##[1:6] first_drive_fault_flag)
    else $error("fault flag not set");
  a_fault_stays_set: assert property (
    (ana && !band) [*3] ##0 first_drive_fault_flag |=> first_drive_fault_flag)
    else $error("fault cleared outside band");
  a_fault_clears_band: assert property (
    (ana && band && bridge_status[0] == 2'h0) [*8] |-> !first_drive_fault_flag)
    else $error("fault kept inside band");
  a_strap_brakes: assert property (
    (!addr_strap_b && !mode_state[2]) [*8] |-> dynamic_brake) else $error("brake not dynamic");
  a_strap_free: assert property (
    (addr_strap_b && !mode_state[2]) [*8] |-> !dynamic_brake) else $error("brake not free");
endmodule
bind ram_motor_command ram_cmd_chk i_chk (
  .clock, .rst_b, .addr_strap_b, .bridge_status, .adc_sample, .mode_state, .drive,
  .first_drive_fault_flag, .second_drive_fault_flag, .dynamic_brake
);
`default_nettype wire

/* File: sim/ram_servo_src.sv */
// Servo receiver model: one frame, channel one leads
`timescale 1ns/100ps
`default_nettype none
module ram_servo_src #(
  parameter int W_ONE = 505,
  parameter int W_TWO = 200
) (
  input  wire logic clock,
  input  wire logic fire,
  output logic      ch_one,
  output logic      ch_two
);
  // A single frame; a train would repeat well inside 25 ms
  initial
  begin
    ch_one = 1'b0;
    ch_two = 1'b0;
    @(posedge fire);
    fork
      begin
        @(negedge clock);
        ch_one = 1'b1;
        repeat (W_ONE * 200) @(negedge clock);
        ch_one = 1'b0;
      end
      begin
        repeat (2000) @(negedge clock);
        ch_two = 1'b1;
        repeat (W_TWO * 200) @(negedge clock);
        ch_two = 1'b0;
      end
    join
  end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the motor command block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module tb_top;
  logic                      clock = 1'b0;
  logic                      rst_b = 1'b0;
  logic [1:0]                mode_pins = 2'h0;
  logic                      addr_strap_b = 1'b1;
  logic                      fire = 1'b0;
  logic                      ch_one;
  logic                      ch_two;
  ram_pkg::ram_bridge_t [1:0] bridge_status = '0;
  ram_pkg::ram_adc_t [1:0]    adc_sample = '0;
  ram_pkg::ram_duty_t [1:0]   serial_duty = '0;
  logic [1:0]                clear_fault_cmd = 2'h0;
  logic [2:0]                mode_state;
  ram_pkg::ram_drive_t [1:0] drive;
  logic                      flag_one;
  logic                      flag_two;
  logic                      dynamic_brake;
  int                        error_cnt = 0;
  int                        n_checks = 0;
  int                        cyc = 0;
  // Rows: reading, expected duty
  logic [19:0] rows [5] = '{20'h00c00, 20'h7fff8, 20'h80000, 20'h81008, 20'hff3f8};
  ram_motor_command #(.TIMEOUT_TICKS(15'h0bb8)) i_dut (
    .clock, .rst_b, .mode_pins, .addr_strap_b, .bridge_status, .adc_sample,
    .channel_one_command_input (ch_one),
    .channel_two_command_input (ch_two),
    .serial_duty               (serial_duty),
    .clear_fault_cmd           (clear_fault_cmd),
    .serial_brake_free         (1'b1),
    .first_drive_fault_flag    (flag_one),
    .second_drive_fault_flag   (flag_two),
    .mode_state, .drive, .dynamic_brake
  );
  ram_servo_src i_src (.clock, .fire, .ch_one, .ch_two);
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic adc(input logic [7:0] a, input logic [7:0] b);
    adc_sample <= {1'b1, b, 1'b1, a};
    wt(1);
    adc_sample <= {1'b0, b, 1'b0, a};
    wt(3);
  endtask
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 110000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  initial
  begin
    wt(20);
    rst_b <= 1'b1;
    wt(8);
    foreach (rows[i])
    begin
      adc(rows[i][19:12], rows[i][19:12]);
      `CHK(drive[0].duty, rows[i][11:0])
      `CHK(drive[1].duty, rows[i][11:0])
    end
    $display("test analog table done");
    adc(8'hff, 8'hff);
    bridge_status[0].over_current <= 1'b1;
    wt(8);
    `CHK(flag_one, 1'b1)
    `CHK(drive[0], 13'h0000)
    `CHK(flag_two, 1'b0)
    bridge_status[0] <= 2'h0;
    wt(12);
    `CHK(flag_one, 1'b1)
    adc(8'h7c, 8'hff);
    wt(6);
    `CHK(flag_one, 1'b0)
    `CHK(drive[0].duty, 12'hfe0)
    bridge_status[1].over_temp <= 1'b1;
    wt(8);
    `CHK(flag_two, 1'b1)
    `CHK(drive[1].enable, 1'b0)
    bridge_status[1] <= 2'h0;
    adc(8'h7c, 8'h84);
    wt(6);
    `CHK(flag_two, 1'b0)
    $display("test fault done");
    addr_strap_b <= 1'b0;
    wt(10);
    `CHK(dynamic_brake, 1'b1)
    addr_strap_b <= 1'b1;
    wt(10);
    `CHK(dynamic_brake, 1'b0)
    $display("test brake done");
    mode_pins <= 2'h1;
    wt(10);
    `CHK(mode_state, 3'h2)
    fire <= 1'b1;
    wt(43000);
    `CHK(drive[1].duty, 12'h000)
    wt(58200);
    `CHK(drive[0].duty, 12'hc01)
    $display("test servo done");
    mode_pins <= 2'h2;
    serial_duty <= {12'h100, 12'hf00};
    wt(10);
    `CHK(mode_state, 3'h4)
    `CHK(drive[1].duty, 12'h100)
    bridge_status[0].over_current <= 1'b1;
    wt(8);
    `CHK(flag_one, 1'b1)
    clear_fault_cmd <= 2'h1;
    wt(1);
    clear_fault_cmd <= 2'h0;
    bridge_status[0] <= 2'h0;
    wt(8);
    `CHK(flag_one, 1'b1)
    clear_fault_cmd <= 2'h1;
    wt(1);
    clear_fault_cmd <= 2'h0;
    wt(2);
    `CHK(flag_one, 1'b0)
    `CHK(drive[0], 13'h1f00)
    $display("test serial done");
    bridge_status[0].over_current <= 1'b1;
    wt(8);
    rst_b <= 1'b0;
    wt(2);
    `CHK(flag_one, 1'b0)
    `CHK(drive, 26'h0)
    rst_b <= 1'b1;
    wt(8);
    `CHK(flag_one, 1'b1)
    `CHK(drive[0].enable, 1'b0)
    $display("test reset done");
    complete_run();
  end
endmodule
`default_nettype wire
